// >>> logic/aicc_cfg.svh
// Purpose: Constants for the converter input configuration and coding control
// Assumes: Pins sampled synchronously on sys_clk at 10 MHz
// Notes: Serial clock and chip select arrive as ordinary sampled inputs
// Contract
// - Select low gives three differential pairs
// - Select high gives six single-ended channels
// - Return to track on thirteenth rising edge
// - Mode change mid conversion restarts acquisition
// - Single-ended codes 0-5 route inputs 1-6
// - Differential pair by upper bits, bit0 pseudo
// - Range low one reference, high twice reference
// - Straight binary only single/pseudo low range
// - LSB scale from mode and range
// - Sample and start on chip-select fall
// - Conversion occupies fourteen serial clock cycles
`ifndef AICC_CFG_SVH
`define AICC_CFG_SVH
`define AICC_TRACK_EDGE 4'hD
`define AICC_DONE_EDGE 4'hE
`define AICC_CNT_ZERO 4'h0
`define AICC_CNT_ONE 4'h1
`define AICC_SEL_NONE 3'h0
`define AICC_SE_LAST 3'h5
`define AICC_NEG_ANALOG_GROUND 3'h0
`define AICC_LSB_X1 2'h0
`define AICC_LSB_X2 2'h1
`define AICC_LSB_X4 2'h2
`endif

// >>> logic/aicc_pkg.sv
// Purpose: Types for the converter input configuration and coding control
// Assumes: None
// Notes: Shared by the top module and the snapshot store
package aicc_pkg;
    typedef enum logic [1:0] {
        AICC_MODE_SE = 2'b00,
        AICC_MODE_FULL = 2'b01,
        AICC_MODE_PSEUDO = 2'b10
    } aicc_mode_type;
    typedef enum logic [1:0] {
        AICC_ST_TRACK = 2'b00,
        AICC_ST_HOLD = 2'b01,
        AICC_ST_DONE = 2'b10
    } aicc_state_type;
endpackage

// >>> logic/aicc_snap.sv
// Purpose: Holds the configuration captured at the sampling edge
// Assumes: Capture strobe is a one-cycle pulse
// Notes: Read data come straight from registers
`timescale 1ns/10ps
module aicc_snap (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Capture side
    input wire logic cap_en,
    input wire aicc_pkg::aicc_mode_type mode_in,
    input wire logic range_in,
    // Held values
    output aicc_pkg::aicc_mode_type mode_q,
    output logic range_q
);
    import aicc_pkg::*;
    // Capture mode and range on each conversion start
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= AICC_MODE_SE;
            range_q <= 1'b0;
        end else if (cap_en) begin
            mode_q <= mode_in;
            range_q <= range_in;
        end
    end
endmodule

// >>> logic/aicc_top.sv
// Purpose: Decodes input type, channel address and range into routing and coding
// Assumes: Host keeps the settle and hold times on its pins
// Notes: Serial clock edges are found by sampling at sys_clk
`timescale 1ns/10ps
`include "aicc_cfg.svh"
module aicc_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Frame pins
    input wire logic chip_sel_n,
    input wire logic ser_clk,
    // Configuration pins
    input wire logic input_type_select,
    input wire logic chan_addr_bit0,
    input wire logic chan_addr_bit1,
    input wire logic chan_addr_bit2,
    input wire logic range_select,
    // Multiplexer routing, same for both converters
    output logic [2:0] pos_sel_r,
    output logic [2:0] neg_sel_r,
    output logic neg_is_gnd_r,
    // Conversion status
    output logic track_r,
    output logic conv_start_r,
    output logic conv_done_r,
    output logic acq_restart_r,
    output logic addr_reserved_r,
    // Coding and scaling of the current result
    output logic twos_comp_r,
    output logic [1:0] lsb_scale_r,
    output logic span_double_r
);
    import aicc_pkg::*;

    // Both internal converters share one multiplexer address, so one set of
    // routing outputs serves them. Routing follows the pins every cycle, while
    // coding and scaling come from the snapshot taken as the frame opens, so a
    // late range change cannot disturb the result already in flight.

    ////////////////////////////////////////////////////////////////////////////
    // Decode functions
    // Mode seen by the converter; bit0 picks pseudo only when differential
    function automatic aicc_mode_type mode_of(input logic sgl, input logic a0);
        if (sgl) begin
            mode_of = AICC_MODE_SE;
        end else if (a0) begin
            mode_of = AICC_MODE_PSEUDO;
        end else begin
            mode_of = AICC_MODE_FULL;
        end
    endfunction

    // Straight binary only for ground or pseudo referenced inputs in the low span
    function automatic logic is_twos(input aicc_mode_type m, input logic rng);
        is_twos = !((m != AICC_MODE_FULL) && !rng);
    endfunction

    // Differential inputs swing both ways, so their step is twice as large
    function automatic logic [1:0] lsb_of(input aicc_mode_type m, input logic rng);
        if (m == AICC_MODE_SE) begin
            lsb_of = rng ? `AICC_LSB_X2 : `AICC_LSB_X1;
        end else begin
            lsb_of = rng ? `AICC_LSB_X4 : `AICC_LSB_X2;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on frame pins
    logic cs_d_r;
    logic sclk_d_r;
    logic cs_fall;
    logic sclk_rise;
    logic [2:0] addr;
    aicc_mode_type mode_now;
    aicc_mode_type mode_d_r;
    aicc_mode_type snap_mode;
    logic snap_range;
    assign cs_fall = cs_d_r && !chip_sel_n;
    assign sclk_rise = !sclk_d_r && ser_clk && !chip_sel_n;
    assign addr = {chan_addr_bit2, chan_addr_bit1, chan_addr_bit0};
    assign mode_now = mode_of(input_type_select, chan_addr_bit0);

    // Previous pin levels
    // Both histories reset to the idle level of their pins: the serial clock
    // rests high, so no false rise follows reset. A select already low at
    // release opens a frame at once.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_d_r <= 1'b1;
            sclk_d_r <= 1'b1;
            mode_d_r <= AICC_MODE_SE;
        end else begin
            cs_d_r <= chip_sel_n;
            sclk_d_r <= ser_clk;
            mode_d_r <= mode_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame state machine and serial clock counter
    aicc_state_type state_r;
    aicc_state_type state_nxt;
    logic [3:0] edge_cnt_r;
    logic [3:0] edge_cnt_nxt;

    // The counter holds at the last edge, so extra clocks in a long frame do nothing
    // Raising chip select at any point ends the frame and returns to track
    // Next state
    always_comb begin
        state_nxt = state_r;
        edge_cnt_nxt = edge_cnt_r;
        case (state_r)
            AICC_ST_TRACK: begin
                if (cs_fall) begin
                    state_nxt = AICC_ST_HOLD;
                    edge_cnt_nxt = `AICC_CNT_ZERO;
                end
            end
            AICC_ST_HOLD: begin
                if (chip_sel_n) begin
                    state_nxt = AICC_ST_TRACK;
                end else if (sclk_rise) begin
                    edge_cnt_nxt = edge_cnt_r + `AICC_CNT_ONE;
                    if (edge_cnt_r + `AICC_CNT_ONE == `AICC_TRACK_EDGE) begin
                        state_nxt = AICC_ST_DONE;
                    end
                end
            end
            AICC_ST_DONE: begin
                if (chip_sel_n) begin
                    state_nxt = AICC_ST_TRACK;
                end else if (sclk_rise && edge_cnt_r != `AICC_DONE_EDGE) begin
                    edge_cnt_nxt = edge_cnt_r + `AICC_CNT_ONE;
                end
            end
            default: begin
                state_nxt = AICC_ST_TRACK;
            end
        endcase
    end

    // State registers, reset together so no stale count survives a reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= AICC_ST_TRACK;
            edge_cnt_r <= `AICC_CNT_ZERO;
        end else begin
            state_r <= state_nxt;
            edge_cnt_r <= edge_cnt_nxt;
        end
    end

    // Track follows the next state, so it rises the cycle after the thirteenth rise
    // Start and done are single-cycle pulses
    // Status outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            track_r <= 1'b1;
            conv_start_r <= 1'b0;
            conv_done_r <= 1'b0;
            acq_restart_r <= 1'b0;
        end else begin
            track_r <= (state_nxt != AICC_ST_HOLD);
            conv_start_r <= (state_r == AICC_ST_TRACK) && cs_fall;
            conv_done_r <= (state_r == AICC_ST_DONE) && sclk_rise && !chip_sel_n
                && (edge_cnt_r + `AICC_CNT_ONE == `AICC_DONE_EDGE);
            // Mode change while holding restarts acquisition
            acq_restart_r <= (state_r == AICC_ST_HOLD) && !chip_sel_n
                && (mode_now != mode_d_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reserved codes still route somewhere; the flag marks the result undefined
    // Multiplexer routing follows the pins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_sel_r <= `AICC_SEL_NONE;
            neg_sel_r <= `AICC_NEG_ANALOG_GROUND;
            neg_is_gnd_r <= 1'b1;
            addr_reserved_r <= 1'b0;
        end else if (input_type_select) begin
            pos_sel_r <= addr;
            neg_sel_r <= `AICC_NEG_ANALOG_GROUND;
            neg_is_gnd_r <= 1'b1;
            addr_reserved_r <= addr > `AICC_SE_LAST;
        end else begin
            pos_sel_r <= {addr[2:1], 1'b0};
            neg_sel_r <= {addr[2:1], 1'b1};
            neg_is_gnd_r <= 1'b0;
            addr_reserved_r <= addr[2] && addr[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture only at a true frame opening; a fall seen in other states is ignored
    // Snapshot of mode and range at sampling edge
    aicc_snap u_snap (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cap_en(cs_fall && state_r == AICC_ST_TRACK),
        .mode_in(mode_now),
        .range_in(range_select),
        .mode_q(snap_mode),
        .range_q(snap_range)
    );

    // Coding outputs lag the capture by one cycle and then stand until the next
    // frame opens, whatever the pins do meanwhile
    // Coding and scale from captured settings
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            twos_comp_r <= 1'b0;
            lsb_scale_r <= `AICC_LSB_X1;
            span_double_r <= 1'b0;
        end else begin
            twos_comp_r <= is_twos(snap_mode, snap_range);
            lsb_scale_r <= lsb_of(snap_mode, snap_range);
            span_double_r <= snap_range;
        end
    end
endmodule

// >>> verification/aicc_chk_properties.sv
// Purpose: Checks routing, framing and coding at the top ports
// Assumes: Frames open with ser_clk high
// Notes: Bound to every aicc_top
`timescale 1ns/10ps
module aicc_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pins
    input wire logic chip_sel_n,
    input wire logic ser_clk,
    input wire logic input_type_select,
    input wire logic chan_addr_bit0,
    input wire logic chan_addr_bit1,
    input wire logic chan_addr_bit2,
    input wire logic range_select,
    // Outputs watched
    input wire logic [2:0] pos_sel_r,
    input wire logic [2:0] neg_sel_r,
    input wire logic neg_is_gnd_r,
    input wire logic track_r,
    input wire logic conv_start_r,
    input wire logic conv_done_r,
    input wire logic acq_restart_r,
    input wire logic addr_reserved_r,
    input wire logic twos_comp_r,
    input wire logic span_double_r,
    input wire logic [1:0] lsb_scale_r
);
    logic ok, sp;
    logic [3:0] rc;
    // Address, expected coding and mode seen at the pins
    wire [2:0] ad = {chan_addr_bit2, chan_addr_bit1, chan_addr_bit0};
    wire tw = range_select | ~(input_type_select | chan_addr_bit0);
    wire [1:0] ls = {~input_type_select & range_select, ~(input_type_select ^ range_select)};
    wire [1:0] md = {input_type_select, ~input_type_select & chan_addr_bit0};
    wire rise = ser_clk & ~sp & ~chip_sel_n;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    // Settled flag, last serial clock and rises in the frame
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ok <= 1'b0;
            sp <= 1'b1;
            rc <= 4'h0;
        end else begin
            ok <= 1'b1;
            sp <= ser_clk;
            rc <= chip_sel_n ? 4'h0 : rc + {3'h0, rise};
        end
    end
    property p_se;
        ok && $past(input_type_select) && $past(ad) < 3'h6
            |-> pos_sel_r == $past(ad) && neg_sel_r == 3'h0 && neg_is_gnd_r;
    endproperty
    a_se: assert property (p_se) else $error("se route");
    property p_df;
        ok && !$past(input_type_select) && $past(ad) < 3'h6 |-> !neg_is_gnd_r
            && pos_sel_r == ($past(ad) & 3'h6) && neg_sel_r == ($past(ad) | 3'h1);
    endproperty
    a_df: assert property (p_df) else $error("diff route");
    property p_rsv;
        ok |-> addr_reserved_r == ($past(ad) > 3'h5);
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved");
    property p_start;
        track_r && $fell(chip_sel_n) |=> conv_start_r && !track_r;
    endproperty
    a_start: assert property (p_start) else $error("start");
    property p_code;
        conv_start_r |=> twos_comp_r == $past(tw, 2) && lsb_scale_r == $past(ls, 2)
            && span_double_r == $past(range_select, 2);
    endproperty
    a_code: assert property (p_code) else $error("coding");
    property p_track;
        rise && rc == 4'hC |=> track_r;
    endproperty
    a_track: assert property (p_track) else $error("track");
    property p_done;
        rise && rc == 4'hD |=> conv_done_r;
    endproperty
    a_done: assert property (p_done) else $error("done");
    property p_rst;
        !track_r && !chip_sel_n && $changed(md) |=> acq_restart_r;
    endproperty
    a_rst: assert property (p_rst) else $error("restart");
endmodule
bind aicc_top aicc_chk u_chk (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .chip_sel_n(chip_sel_n),
    .ser_clk(ser_clk),
    .input_type_select(input_type_select),
    .chan_addr_bit0(chan_addr_bit0),
    .chan_addr_bit1(chan_addr_bit1),
    .chan_addr_bit2(chan_addr_bit2),
    .range_select(range_select),
    .pos_sel_r(pos_sel_r),
    .neg_sel_r(neg_sel_r),
    .neg_is_gnd_r(neg_is_gnd_r),
    .track_r(track_r),
    .conv_start_r(conv_start_r),
    .conv_done_r(conv_done_r),
    .acq_restart_r(acq_restart_r),
    .addr_reserved_r(addr_reserved_r),
    .twos_comp_r(twos_comp_r),
    .span_double_r(span_double_r),
    .lsb_scale_r(lsb_scale_r)
);

// >>> verification/aicc_host.sv
// Purpose: Host that frames conversions with chip select and serial clock
// Assumes: go sampled on the falling edge of sys_clk
// Notes: Serial clock rests high between frames
`timescale 1ns/10ps
module aicc_host (
    // Clock and request
    input wire logic sys_clk,
    input wire logic go,
    // Frame pins
    output logic chip_sel_n,
    output logic ser_clk,
    output logic busy
);
    ////////////////////////////////////////////////////////////
    // Idle levels, then one frame of fourteen serial clocks per request
    initial begin
        chip_sel_n = 1'b1;
        ser_clk = 1'b1;
        busy = 1'b0;
        forever begin
            @(negedge sys_clk);
            if (go === 1'b1) begin
                busy = 1'b1;
                chip_sel_n = 1'b0;
                repeat (14) begin
                    @(negedge sys_clk) ser_clk = 1'b0;
                    @(negedge sys_clk) ser_clk = 1'b1;
                end
                @(negedge sys_clk) chip_sel_n = 1'b1;
                @(negedge sys_clk) busy = 1'b0;
            end
        end
    end
endmodule

// >>> verification/testbench.sv
// Purpose: Self-checking bench for the input configuration control
// Assumes: Host model makes the frames
// Notes: Pins change at the falling edge of sys_clk
`timescale 1ns/10ps
module testbench;
    logic sys_clk = 1'b0, rst_n = 1'b0, sel = 1'b0, rng = 1'b0, go = 1'b0;
    logic [2:0] ad = 3'h0, pos_sel_r, neg_sel_r;
    logic [1:0] lsb_scale_r;
    logic chip_sel_n, ser_clk, busy, neg_is_gnd_r, track_r, conv_start_r, conv_done_r;
    logic acq_restart_r, addr_reserved_r, twos_comp_r, span_double_r;
    logic [6:0] e;
    integer mismatches = 0, compares = 0, seed = 32'h8846BF94, dn = 0, rs = 0, st = 0, j, v;
    ////////////////////////////////////////////////////////////
    // Clock, host and design
    always #50 sys_clk = ~sys_clk;
    aicc_host host (.sys_clk(sys_clk), .go(go), .chip_sel_n(chip_sel_n), .ser_clk(ser_clk),
        .busy(busy));
    aicc_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .chip_sel_n(chip_sel_n), .ser_clk(ser_clk),
        .input_type_select(sel), .chan_addr_bit0(ad[0]), .chan_addr_bit1(ad[1]),
        .chan_addr_bit2(ad[2]), .range_select(rng), .pos_sel_r(pos_sel_r),
        .neg_sel_r(neg_sel_r), .neg_is_gnd_r(neg_is_gnd_r), .track_r(track_r),
        .conv_start_r(conv_start_r), .conv_done_r(conv_done_r), .acq_restart_r(acq_restart_r),
        .addr_reserved_r(addr_reserved_r), .twos_comp_r(twos_comp_r),
        .lsb_scale_r(lsb_scale_r), .span_double_r(span_double_r));
    // Pulse counters
    always @(posedge sys_clk) begin
        dn = dn + (conv_done_r === 1'b1);
        st = st + (conv_start_r === 1'b1);
        rs = rs + (acq_restart_r === 1'b1);
    end
    function logic [6:0] route(input logic s, input logic [2:0] a);
        route = s ? {a, 4'h1} : {a & 3'h6, a | 3'h1, 1'b0};
    endfunction
    task chk(input logic [6:0] got, input logic [6:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask
    task results;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task frame(input logic [1:0] f);
        integer k;
        go <= 1'b1;
        fork
            begin
                for (k = 0; k < 9 && busy !== 1'b1; k++) @(posedge sys_clk);
                if (busy !== 1'b1) begin
                    mismatches++;
                    results;
                end
                @(negedge sys_clk) go <= 1'b0;
                for (k = 0; k < 60 && busy === 1'b1; k++) @(posedge sys_clk);
                if (busy !== 1'b0) begin
                    mismatches++;
                    results;
                end
            end
            begin
                repeat (f[0] ? 8 : 4) @(negedge sys_clk);
                if (f[0]) rng <= ~rng;
                if (f[1]) ad[0] <= ~ad[0];
            end
        join
        @(negedge sys_clk);
    endtask
    initial begin
        repeat (3) @(negedge sys_clk);
        chk({pos_sel_r, neg_sel_r, neg_is_gnd_r}, 7'h01, "reset route");
        chk({3'h0, track_r, twos_comp_r, lsb_scale_r}, 7'h08, "reset state");
        rst_n <= 1'b1;
        $display("test reset done");
        // Every code, then random codes
        for (j = 0; j < 48; j++) begin
            v = j < 16 ? j : $random(seed);
            sel <= v[3];
            ad <= v[2:0];
            repeat (2) @(negedge sys_clk);
            e = route(v[3], v[2:0]);
            if (v[2:0] < 3'h6) chk({pos_sel_r, neg_sel_r, neg_is_gnd_r}, e, "route");
            chk({6'h0, addr_reserved_r}, {6'h0, v[2:0] > 3'h5}, "reserved");
        end
        $display("test routing done");
        // Every mode and range, range moved mid frame half the time
        for (j = 0; j < 16; j++) begin
            v = $unsigned($random(seed)) % 3;
            sel <= j[0];
            rng <= j[1];
            ad <= {v[1:0], j[2]};
            repeat (2) @(negedge sys_clk);
            e = {3'h0, j[1] | ~(j[0] | j[2]), ~j[0] & j[1], ~(j[0] ^ j[1]), j[1]};
            frame({1'b0, j[3]});
            chk({3'h0, twos_comp_r, lsb_scale_r, span_double_r}, e, "coding");
            chk({6'h0, track_r}, 7'h01, "track");
        end
        $display("test coding done");
        sel <= 1'b0;
        ad <= 3'h2;
        repeat (2) @(negedge sys_clk);
        frame(2'h2);
        chk(rs[6:0], 7'h01, "restart");
        chk(dn[6:0], 7'h11, "frames");
        chk(st[6:0], 7'h11, "starts");
        $display("test restart done");
        results;
    end
endmodule
